/* File: design/serial_pin_port_consts.vh */
// Constants for the two-wire serial pin port
`ifndef SERIAL_PIN_PORT_CONSTS_VH
`define SERIAL_PIN_PORT_CONSTS_VH
`define SPC_REG_INDEX 8'haf
`define SPC_BYTE_ADDR 10'h2bc
`define SPC_ADDR_W 10
`define SPC_RESET 8'h00
`define SPC_BIT_CLK_DIR 0
`define SPC_BIT_DATA_DIR 1
`define SPC_BIT_CLK_BUF 2
`define SPC_BIT_DATA_BUF 3
`define SPC_BIT_PULLUP 7
`define SPC_IMPL_MASK 8'h8f
`define SPC_WR_MASK 8'h83
`endif

/* File: design/pin_sync3.v */
// Three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync3 (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire pin_i,
    output reg level_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    // Shift chain; level follows only when stages two and three agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level_o <= 1'b1;
        end else if (ce_i) begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_o <= s3_q;
            end
        end
    end
endmodule // pin_sync3

/* File: design/kbd_mouse_serial_pin_port.v */
// Open-drain clock/data pin port with one control register on Wishbone
`timescale 1ns/100ps
`include "serial_pin_port_consts.vh"

// Operation
// - Firmware frames: start low/low, eight bits LSB first, parity, stop.
// - Parity is odd over eight data bits plus parity bit.
// - Firmware toggles the clock pin at about 15 kHz.
// - Device acknowledges host frame by pulling data low after stop.
// - Both pins are open-drain; the port only ever pulls low.
// - Bit 1 data direction, bit 0 clock direction; 1 means output.
// - Bits 3 and 2 drive outputs and show input levels.
// - Bit 7 connects the 5 kilohm pull-ups on both pins.
// - Reset clears pull-up, buffers and directions; pins start as inputs.
// - No serializer here; firmware does all framing through the register.
module kbd_mouse_serial_pin_port (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`SPC_ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire clk_pin_i,
    output reg clk_pin_o,
    output reg clk_pin_oe_o,
    input wire data_pin_i,
    output reg data_pin_o,
    output reg data_pin_oe_o,
    output reg pullup_en_o
);
    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    wire clk_level;
    wire data_level;
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    wire hit;
    wire [7:0] read_val;

    pin_sync3 clk_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(clk_pin_i),
        .level_o(clk_level)
    );

    pin_sync3 data_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(data_pin_i),
        .level_o(data_level)
    );

    // ------------------------------------------------------------
    // Register write path
    // ------------------------------------------------------------
    assign hit = (wb_adr_i == `SPC_BYTE_ADDR);

    // Writes store pull-up, directions and buffers; unused bits dropped
    always @* begin
        ctrl_d = ctrl_q;
        if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && hit && wb_sel_i[0]) begin
            ctrl_d = wb_dat_i[7:0] & `SPC_IMPL_MASK;
        end
    end

    // Control register; an input-mode buffer tracks the pin level
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `SPC_RESET;
        end else if (ce_i) begin
            ctrl_q <= ctrl_d;
            if (!ctrl_d[`SPC_BIT_CLK_DIR]) begin
                ctrl_q[`SPC_BIT_CLK_BUF] <= clk_level;
            end
            if (!ctrl_d[`SPC_BIT_DATA_DIR]) begin
                ctrl_q[`SPC_BIT_DATA_BUF] <= data_level;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path and acknowledge
    // ------------------------------------------------------------
    // Reads show live pin levels for inputs, stored value for outputs
    assign read_val = {ctrl_q[`SPC_BIT_PULLUP], 3'h0,
        ctrl_q[`SPC_BIT_DATA_DIR] ? ctrl_q[`SPC_BIT_DATA_BUF] : data_level,
        ctrl_q[`SPC_BIT_CLK_DIR] ? ctrl_q[`SPC_BIT_CLK_BUF] : clk_level,
        ctrl_q[`SPC_BIT_DATA_DIR], ctrl_q[`SPC_BIT_CLK_DIR]};

    // One-cycle ack; unmapped addresses ack and read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce_i) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= (hit && !wb_we_i) ? {24'h0, read_val} : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Open-drain pin drivers
    // ------------------------------------------------------------
    // Drive low only when output mode and buffer is zero; framing is firmware's
    always @(posedge clk_i) begin
        if (rst_i) begin
            clk_pin_o <= 1'b0;
            clk_pin_oe_o <= 1'b0;
            data_pin_o <= 1'b0;
            data_pin_oe_o <= 1'b0;
            pullup_en_o <= 1'b0;
        end else if (ce_i) begin
            clk_pin_o <= 1'b0;
            data_pin_o <= 1'b0;
            clk_pin_oe_o <= ctrl_d[`SPC_BIT_CLK_DIR] && !ctrl_d[`SPC_BIT_CLK_BUF];
            data_pin_oe_o <= ctrl_d[`SPC_BIT_DATA_DIR] && !ctrl_d[`SPC_BIT_DATA_BUF];
            pullup_en_o <= ctrl_d[`SPC_BIT_PULLUP];
        end
    end
endmodule // kbd_mouse_serial_pin_port

/* File: testbench/spp_asserts.sv */
// Checker for the serial pin port
`timescale 1ns/100ps
`include "serial_pin_port_consts.vh"
module spp_asserts (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`SPC_ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire clk_pin_oe_o,
    input wire data_pin_oe_o,
    input wire pullup_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request taken, and a write to the control register
    sequence tk; ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence wr; tk ##0 wb_we_i && wb_sel_i[0] && wb_adr_i == `SPC_BYTE_ADDR; endsequence
    a_ack_next: assert property (tk |=> wb_ack_o) else $error("ack late");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_clk_pull: assert property (wr ##0 wb_dat_i[0] && !wb_dat_i[2] |=> clk_pin_oe_o) else $error("clk oe");
    a_data_input: assert property (wr ##0 !wb_dat_i[1] |=> !data_pin_oe_o) else $error("data oe");
    a_data_release: assert property (wr ##0 wb_dat_i[3] |=> !data_pin_oe_o) else $error("release");
    a_pullup_on: assert property (wr ##0 wb_dat_i[7] |=> pullup_en_o) else $error("pullup");
    a_spare_zero: assert property (wb_ack_o |-> wb_dat_o[6:4] == 3'h0) else $error("spare");
    a_pins_quiet: assert property ($changed({clk_pin_oe_o, data_pin_oe_o}) |-> wb_ack_o) else $error("pins");
endmodule // spp_asserts
bind kbd_mouse_serial_pin_port spp_asserts spp_asserts_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .clk_pin_oe_o, .data_pin_oe_o, .pullup_en_o);

/* File: testbench/host_model.sv */
// Host end of the open-drain link
`timescale 1ns/100ps
module host_model (
    input wire clk_i,
    input wire [2:0] pull_i,
    input wire pu_i,
    output wire [1:0] lvl_o
);
    reg flt_q = 1'b0;
    // Low when pulled, high on pull-up, else wandering
    always @(posedge clk_i) flt_q <= ~flt_q;
    assign lvl_o = {~pull_i[1] & (pu_i | flt_q), ~(pull_i[0] | pull_i[2]) & (pu_i | flt_q)};
endmodule // host_model

/* File: testbench/test_kbd_mouse_serial_pin_port.sv */
// Bench for the serial pin port
`timescale 1ns/100ps
`include "serial_pin_port_consts.vh"
module test_kbd_mouse_serial_pin_port;
    reg clk_i = 0, rst_i = 1, cyc = 0, we = 0, hold = 0;
    reg [9:0] adr = 0;
    reg [7:0] wd = 0, q;
    reg [10:0] fr, f = {1'b1, ~^8'ha6, 8'ha6, 1'b0};
    wire [31:0] rd;
    wire ack, pu, c_oe, d_oe;
    wire [1:0] lv;
    integer miscompares = 0, tests_run = 0, i;
    always #2.5 clk_i = ~clk_i;
    // Host shifts in data on each falling link clock
    always @(negedge lv[0]) fr <= {lv[1], fr[10:1]};
    kbd_mouse_serial_pin_port kbd_mouse_serial_pin_port_i (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wd}), .wb_dat_o(rd),
        .wb_ack_o(ack), .clk_pin_i(lv[0]), .clk_pin_o(), .clk_pin_oe_o(c_oe), .data_pin_i(lv[1]), .data_pin_o(),
        .data_pin_oe_o(d_oe), .pullup_en_o(pu));
    host_model host_model_i (.clk_i, .pull_i({hold, d_oe, c_oe}), .pu_i(pu), .lvl_o(lv));
    // One bus cycle, held until ack
    task bus(input w, input [9:0] a, input [7:0] v);
        begin
            @(posedge clk_i);
            cyc <= 1; we <= w; adr <= a; wd <= v;
            @(posedge clk_i);
            while (ack !== 1'b1) @(posedge clk_i);
            q = rd[7:0];
            cyc <= 0;
            if (ack !== 1'b1) miscompares = miscompares + 1;
        end
    endtask
    task chk(input [10:0] g, e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin miscompares = miscompares + 1; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
        end
    endtask
    task conclude;
        begin
            $display("miscompares %0d tests_run %0d", miscompares, tests_run);
            if (miscompares == 0 && tests_run > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    initial begin #4000; miscompares = miscompares + 1; conclude; end
    // Register checks, then a bit-banged frame
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        bus(0, `SPC_BYTE_ADDR, 0); chk(q & 8'hf3, 0);
        bus(1, `SPC_BYTE_ADDR, 8'hff); bus(0, `SPC_BYTE_ADDR, 0); chk(q, 8'h8f);
        bus(1, 10'h0, 8'hff); bus(0, 10'h0, 0); chk(q, 0);
        bus(1, `SPC_BYTE_ADDR, 8'h80); hold <= 1; repeat (8) @(posedge clk_i); // Host clock hold
        bus(0, `SPC_BYTE_ADDR, 0); chk(q, 8'h88);
        hold <= 0;
        bus(1, `SPC_BYTE_ADDR, 8'h82); chk({c_oe, d_oe}, 2'b01);
        for (i = 0; i < 11; i = i + 1) begin
            bus(1, `SPC_BYTE_ADDR, {4'h8, f[i], 3'h7});
            bus(1, `SPC_BYTE_ADDR, {4'h8, f[i], 3'h3});
        end
        chk(fr, f);
        conclude;
    end
endmodule // test_kbd_mouse_serial_pin_port
